// *** ebls_pkg.sv ***
// package for the endian byte lane steering block
// assumes one 50 MHz system clock and a strap sampled at reset
// Function
// - big-endian puts the msb of a long-word at byte address 0.
// - little-endian puts the msb of a long-word at byte address 3.
// - on the 16-bit io bus address bit 1 flips between the byte orders.
// - big-endian upper half is at the low io address, little at the high.
// - the 64-bit co-processor bus passes operands with no swapping.
// - the little-endian left-most phrase pixel holds bit 0, byte 0.
// - the big-endian left-most phrase pixel holds bit 63, still byte 0.
// - a single eight-bit pixel at byte address 0 is left-most in both.
// - the left eight-bit phrase pixel is bits 0-7 little, 56-63 big.
package ebls_pkg;
    localparam int         BYTE_W            = 8;
    localparam int         HALF_W            = 16;
    localparam int         LONG_W            = 32;
    localparam int         PHRASE_W          = 64;
    localparam int         PHRASE_BYTES      = 8;
    localparam int         ADDR_HALF_BIT     = 1;
    localparam logic       STRAP_BIG         = 1'b1;
    localparam logic [1:0] LONG_MSB_ADDR_BIG = 2'h0;
    localparam logic [1:0] LONG_MSB_ADDR_LIT = 2'h3;
    localparam logic [2:0] PIX_LEFT_ADDR     = 3'h0;
endpackage

// *** ebls_strap.sv ***
// three-stage synchroniser and latch for the byte order strap
// assumes rst_n is the already synchronised reset
`timescale 1ns/100ps
module ebls_strap (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // strap pin and latched order
    input  wire logic strap_i,
    output logic      big_o,
    output logic      valid_o
);
    typedef struct packed {
        logic [2:0] sync;
        logic [2:0] fill;
        logic       big;
        logic       valid;
    } ebls_strap_s;
    ebls_strap_s st;
    ebls_strap_s next_st;

    always_comb begin
        next_st = st;
        next_st.sync = {st.sync[1:0], strap_i};
        // ones walk in behind reset; cleared stages would agree at once
        // and latch little-endian before the pin has reached them
        next_st.fill = {st.fill[1:0], 1'b1};
        // catch once, after the stages are full and the later two agree
        if (!st.valid && st.fill[2]
                && (st.sync[1] == st.sync[2])) begin
            next_st.big   = (st.sync[2] == ebls_pkg::STRAP_BIG);
            next_st.valid = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign big_o   = st.big;
    assign valid_o = st.valid;

    a_order_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        valid_o |=> (valid_o && $stable(big_o)))
        else $error("byte order changed after latch");
endmodule

// *** ebls_top.sv ***
// endian byte lane steering: long-word, half-word and phrase steering
// assumes strap pin is asynchronous and held steady around reset
`timescale 1ns/100ps
module ebls_top (
    // clock and reset
    input  wire logic        CLK_SYS_I,
    input  wire logic        RST_N_I,
    // strap
    input  wire logic        ORDER_STRAP_I,
    // long-word byte view
    input  wire logic [31:0] LONG_I,
    input  wire logic [1:0]  LONG_BYTE_ADDR_I,
    output logic      [7:0]  LONG_BYTE_O,
    // io bus half-word view
    input  wire logic [1:0]  IO_ADDR_I,
    output logic      [15:0] IO_HALF_O,
    // io bus writes build a long-word
    input  wire logic        IO_WR_I,
    input  wire logic [15:0] IO_WDATA_I,
    output logic      [31:0] IO_LONG_O,
    // co-processor bus pass-through
    input  wire logic [63:0] COP_DATA_I,
    output logic      [63:0] COP_DATA_O,
    // phrase pixel steering
    input  wire logic [63:0] PHRASE_I,
    input  wire logic [2:0]  PIX_INDEX_I,
    output logic      [7:0]  PIX_BYTE_O,
    output logic      [7:0]  LEFT_PIX_O,
    // status
    output logic             BIG_ENDIAN_O,
    output logic             ORDER_VALID_O
);
    ////////////////////////////////////////////////////////////////////////
    logic [1:0] rst_sync;
    logic       rst_n;
    logic       big;
    logic       valid;

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    ebls_strap u_strap (
        .clk_i   (CLK_SYS_I),
        .rst_n_i (rst_n),
        .strap_i (ORDER_STRAP_I),
        .big_o   (big),
        .valid_o (valid)
    );

    ////////////////////////////////////////////////////////////////////////
    // byte lane that holds byte address a of a long-word
    function automatic logic [1:0] long_lane(input logic b,
                                             input logic [1:0] a);
        // big: address 0 is msb lane 3; little: address 3 is msb lane 3
        long_lane = b ? (ebls_pkg::LONG_MSB_ADDR_LIT - a) : a;
    endfunction

    // byte lane that holds pixel index p of a phrase
    function automatic logic [2:0] pix_lane(input logic b,
                                            input logic [2:0] p);
        pix_lane = b ? (3'(ebls_pkg::PHRASE_BYTES - 1) - p) : p;
    endfunction

    typedef struct packed {
        logic [7:0]  long_byte;
        logic [15:0] io_half;
        logic [31:0] io_long;
        logic [63:0] cop;
        logic [7:0]  pix;
        logic [7:0]  left;
        logic        big;
        logic        valid;
    } ebls_top_s;
    ebls_top_s st;
    ebls_top_s next_st;

    logic       io_upper;
    logic [1:0] lane;
    logic [2:0] plane;

    always_comb begin
        next_st = st;
        next_st.big   = big;
        next_st.valid = valid;
        lane  = long_lane(big, LONG_BYTE_ADDR_I);
        next_st.long_byte = LONG_I[lane*ebls_pkg::BYTE_W +: ebls_pkg::BYTE_W];
        // upper half at low address when big, high address when little
        io_upper = IO_ADDR_I[ebls_pkg::ADDR_HALF_BIT] ^ big;
        next_st.io_half = io_upper
            ? LONG_I[ebls_pkg::LONG_W-1 -: ebls_pkg::HALF_W]
            : LONG_I[ebls_pkg::HALF_W-1:0];
        if (IO_WR_I) begin
            if (io_upper) begin
                next_st.io_long[ebls_pkg::LONG_W-1 -: ebls_pkg::HALF_W] =
                    IO_WDATA_I;
            end else begin
                next_st.io_long[ebls_pkg::HALF_W-1:0] = IO_WDATA_I;
            end
        end
        next_st.cop = COP_DATA_I;
        plane = pix_lane(big, PIX_INDEX_I);
        next_st.pix = PHRASE_I[plane*ebls_pkg::BYTE_W +: ebls_pkg::BYTE_W];
        // left pixel: bits 56-63 big, 0-7 little
        next_st.left = big
            ? PHRASE_I[ebls_pkg::PHRASE_W-1 -: ebls_pkg::BYTE_W]
            : PHRASE_I[ebls_pkg::BYTE_W-1:0];
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign LONG_BYTE_O   = st.long_byte;
    assign IO_HALF_O     = st.io_half;
    assign IO_LONG_O     = st.io_long;
    assign COP_DATA_O    = st.cop;
    assign PIX_BYTE_O    = st.pix;
    assign LEFT_PIX_O    = st.left;
    assign BIG_ENDIAN_O  = st.big;
    assign ORDER_VALID_O = st.valid;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!rst_n);
    // each antecedent also asks for rst_n as sampled, so no attempt starts
    // on the edge that still clears the state and then sees its zeros

    // io write: the half is taken on one edge and shown after it
    sequence s_wr_upper;
        rst_n && IO_WR_I && (IO_ADDR_I[ebls_pkg::ADDR_HALF_BIT] != big);
    endsequence
    sequence s_wr_lower;
        rst_n && IO_WR_I && (IO_ADDR_I[ebls_pkg::ADDR_HALF_BIT] == big);
    endsequence
    sequence s_wr_none;
        rst_n && !IO_WR_I;
    endsequence

    a_msb_big_addr0: assert property (
        (rst_n && big && LONG_BYTE_ADDR_I == ebls_pkg::LONG_MSB_ADDR_BIG)
        |=> LONG_BYTE_O == $past(LONG_I[31:24]))
        else $error("big-endian msb not at address 0");
    a_lsb_big_addr3: assert property (
        (rst_n && big && LONG_BYTE_ADDR_I == ebls_pkg::LONG_MSB_ADDR_LIT)
        |=> LONG_BYTE_O == $past(LONG_I[7:0]))
        else $error("big-endian lsb not at address 3");
    a_msb_lit_addr3: assert property (
        (rst_n && !big && LONG_BYTE_ADDR_I == ebls_pkg::LONG_MSB_ADDR_LIT)
        |=> LONG_BYTE_O == $past(LONG_I[31:24]))
        else $error("little-endian msb not at address 3");
    a_lsb_lit_addr0: assert property (
        (rst_n && !big && LONG_BYTE_ADDR_I == ebls_pkg::LONG_MSB_ADDR_BIG)
        |=> LONG_BYTE_O == $past(LONG_I[7:0]))
        else $error("little-endian lsb not at address 0");
    a_io_a1_sense: assert property (
        (rst_n && IO_ADDR_I[1] == big)
        |=> IO_HALF_O == $past(LONG_I[15:0]))
        else $error("io address bit 1 sense wrong");
    a_io_upper_half: assert property (
        (rst_n && IO_ADDR_I[1] != big)
        |=> IO_HALF_O == $past(LONG_I[31:16]))
        else $error("upper half at wrong io address");
    a_wr_upper_half: assert property (
        s_wr_upper |=> (IO_LONG_O[31:16] == $past(IO_WDATA_I))
            && $stable(IO_LONG_O[15:0]))
        else $error("io write missed the upper half");
    a_wr_lower_half: assert property (
        s_wr_lower |=> (IO_LONG_O[15:0] == $past(IO_WDATA_I))
            && $stable(IO_LONG_O[31:16]))
        else $error("io write missed the lower half");
    a_wr_idle_hold: assert property (
        s_wr_none |=> $stable(IO_LONG_O))
        else $error("io long-word changed without a write");
    a_cop_no_swap: assert property (
        rst_n
        |=> COP_DATA_O == $past(COP_DATA_I))
        else $error("co-processor data altered");
    a_left_lit_bit0: assert property (
        (rst_n && !big)
        |=> LEFT_PIX_O == $past(PHRASE_I[7:0]))
        else $error("little-endian left pixel not at bit 0");
    a_pix_lit_right: assert property (
        (rst_n && !big && PIX_INDEX_I == 3'h7)
        |=> PIX_BYTE_O == $past(PHRASE_I[63:56]))
        else $error("little-endian right pixel not at bit 63");
    a_left_big_bit63: assert property (
        (rst_n && big)
        |=> LEFT_PIX_O == $past(PHRASE_I[63:56]))
        else $error("big-endian left pixel not at bit 63");
    a_pix_big_right: assert property (
        (rst_n && big && PIX_INDEX_I == 3'h7)
        |=> PIX_BYTE_O == $past(PHRASE_I[7:0]))
        else $error("big-endian right pixel not at bit 0");
    a_pix_left_addr0: assert property (
        (rst_n && PIX_INDEX_I == ebls_pkg::PIX_LEFT_ADDR)
        |=> PIX_BYTE_O == LEFT_PIX_O)
        else $error("left pixel not at byte address 0");
    a_phrase_left: assert property (
        rst_n |=> LEFT_PIX_O == ($past(big)
            ? $past(PHRASE_I[63:56]) : $past(PHRASE_I[7:0])))
        else $error("phrase left pixel on wrong bits");
    a_order_copy: assert property (
        (rst_n && valid)
        |=> BIG_ENDIAN_O == $past(big))
        else $error("steering order flag lost");
    a_valid_copy: assert property (
        rst_n
        |=> ORDER_VALID_O == $past(valid))
        else $error("order valid flag lost");
    a_order_fixed: assert property (
        (rst_n && ORDER_VALID_O)
        |=> (ORDER_VALID_O && $stable(BIG_ENDIAN_O)))
        else $error("byte order output changed after latch");
endmodule

// *** ebls_host.sv ***
// board-side model of the byte order strap
// assumes the bench holds big_i steady around reset
`timescale 1ns/100ps
module ebls_host (
    // order chosen by the board
    input  wire logic big_i,
    // strap pin
    output logic      strap_o
);
    // high selects big-endian, low little-endian
    assign strap_o = big_i;
endmodule

// *** testbench.sv ***
// self-checking bench for the endian byte lane steering block
// assumes outputs follow inputs one clock later
`timescale 1ns/100ps
module testbench;
    typedef struct packed {
        logic [7:0]  lb;
        logic [15:0] hw;
        logic [31:0] lw;
        logic [63:0] cop;
        logic [7:0]  pix;
        logic [7:0]  left;
        logic        big;
    } ebls_exp_s;
    logic        clk_sys = 1'b0, rst_n = 1'b0, big_sel = 1'b0, strap;
    logic        io_wr = 1'b0, b;
    logic [31:0] long_i = 32'h0, mdl;
    logic [1:0]  lba = 2'h0, ioa = 2'h0;
    logic [15:0] wd = 16'h0;
    logic [63:0] cop = 64'h0, phr = 64'h0;
    logic [2:0]  pi = 3'h0;
    wire  [7:0]  lb_o, pix_o, left_o;
    wire  [15:0] hw_o;
    wire  [31:0] lw_o;
    wire  [63:0] cop_o;
    wire         big_o, val_o;
    ebls_exp_s   q[$];
    ebls_exp_s   e, x;
    int          n_fail = 0, n_tests = 0, cyc = 0, w;
    always #10 clk_sys = ~clk_sys;
    ebls_host host (.big_i(big_sel), .strap_o(strap));
    ebls_top dut (
        .CLK_SYS_I(clk_sys), .RST_N_I(rst_n), .ORDER_STRAP_I(strap),
        .LONG_I(long_i), .LONG_BYTE_ADDR_I(lba), .LONG_BYTE_O(lb_o),
        .IO_ADDR_I(ioa), .IO_HALF_O(hw_o), .IO_WR_I(io_wr),
        .IO_WDATA_I(wd), .IO_LONG_O(lw_o), .COP_DATA_I(cop),
        .COP_DATA_O(cop_o), .PHRASE_I(phr), .PIX_INDEX_I(pi),
        .PIX_BYTE_O(pix_o), .LEFT_PIX_O(left_o), .BIG_ENDIAN_O(big_o),
        .ORDER_VALID_O(val_o));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // watchdog on a hung run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    // results land one edge after the driver noted them
    always @(posedge clk_sys) begin
        #2;
        if (q.size() > 0) begin
            e = q.pop_front();
            check(lb_o, e.lb);
            check(hw_o, e.hw);
            check(lw_o, e.lw);
            check(cop_o, e.cop);
            check(pix_o, e.pix);
            check(left_o, e.left);
            check(big_o, e.big);
            check(val_o, 1'b1);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(61630));
        for (int m = 0; m < 2; m++) begin
            @(negedge clk_sys);
            b = m[0];
            big_sel = b;
            rst_n = 1'b0;
            repeat (10) @(negedge clk_sys);
            rst_n = 1'b1;
            w = 0;
            while (val_o !== 1'b1 && w < 50) begin
                @(negedge clk_sys);
                w++;
            end
            check(big_o, b);
            mdl = 32'h0;
            for (int i = 0; i < 48; i++) begin
                // latched order must ignore a strap moved after reset
                if (i == 24)
                    big_sel = ~b;
                long_i = $urandom;
                lba = i[1:0];
                ioa = 2'($urandom);
                io_wr = 1'($urandom);
                wd = 16'($urandom);
                cop = {$urandom, $urandom};
                phr = {$urandom, $urandom};
                pi = i[2:0];
                x.lb = b ? long_i[8*(3-lba)+:8] : long_i[8*lba+:8];
                x.hw = (ioa[1] != b) ? long_i[31:16] : long_i[15:0];
                if (io_wr) begin
                    if (ioa[1] != b)
                        mdl[31:16] = wd;
                    else
                        mdl[15:0] = wd;
                end
                x.lw = mdl;
                x.cop = cop;
                x.pix = b ? phr[8*(7-pi)+:8] : phr[8*pi+:8];
                x.left = b ? phr[63:56] : phr[7:0];
                x.big = b;
                q.push_back(x);
                @(negedge clk_sys);
            end
            io_wr = 1'b0;
            $display("test %0d done", m);
        end
        @(negedge clk_sys);
        finish_test();
    end
endmodule
